//--- hdl/lcdcd_top.sv
/*
 * LCD controller command decoder: host bus (8080, 6800 or 4-wire serial),
 * command decode, display state, page/column addressing and display RAM.
 * Assumes all host pins are asynchronous to CLK and strobe pulses last
 * well over four clock cycles.
 */
`timescale 1ns/1ps
// Notes on behaviour
// R1: AFh turns panel on, AEh off
// R2: Display off during all-on enters power save
// R3: 40h-7Fh load six-bit start line
// R4: B0h-B8h load page, display unchanged
// R5: Page 8 stores only data bit 0
// R6: Column set by high and low nibble commands
// R7: Column increments per access; page never advances
// R8: Busy rejects every command
// R9: Status bit 6 shows segment mapping
// R10: Status bit 5 high when display off
// R11: Status bit 4 shows reset; bits 3-0 zero
// R12: Data write stores byte, then increments column
// R13: Host does dummy read after column set
// R14: No display reads over serial
// R15: A0h normal mapping, A1h reversed mapping
// R16: A6h positive image, A7h negative image
// R17: A5h all pixels on, A4h restores
// R18: A2h/A3h select bias set
// R19: E0h saves column; reads stop incrementing
// R20: End restores saved column, leaves mode
// R21: Host sends no column set during RMW
// R22: E2h clears addresses, COM direction and RMW; keeps RAM and display modes
// R23: Cycle type from select line and strobes
// R24: Serial bytes arrive MSB first
// R25: End command decoded as EEh
// R26: Column counter stops at 131
module lcdcd_top #(
    parameter int RESET_BUSY_CYCLES = lcdcd_pkg::RST_BUSY_CYC
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic HARDWARE_RESET_N,
    input wire logic IF_SERIAL,
    input wire logic IF_6800,
    input wire logic CS_N,
    input wire logic COMMAND_DATA_SELECT,
    input wire logic RD_N_E,
    input wire logic WR_N_RW,
    input wire logic SCL,
    input wire logic SDI,
    input wire logic [7:0] D_IN,
    output logic [7:0] D_OUT,
    output logic D_OE,
    output logic DISPLAY_ON,
    output logic ALL_POINTS_ON,
    output logic REVERSE_DISPLAY,
    output logic SEG_NORMAL,
    output logic BIAS_HIGH,
    output logic COM_REVERSE,
    output logic POWER_SAVE,
    output logic RMW_ACTIVE,
    output logic BUSY,
    output logic [lcdcd_pkg::LINE_W-1:0] START_LINE,
    output logic [lcdcd_pkg::PAGE_W-1:0] PAGE_ADDR,
    output logic [lcdcd_pkg::COL_W-1:0] COLUMN_ADDR
);
    import lcdcd_pkg::*;

    localparam int BW = $clog2(RESET_BUSY_CYCLES + 1);
    localparam int PIN_W = 17;
    localparam logic [PIN_W-1:0] PIN_RST = 17'h0_3C00;

    initial begin
        if (RESET_BUSY_CYCLES < 1 || RESET_BUSY_CYCLES > 65535)
            $error("lcdcd_top: RESET_BUSY_CYCLES out of range");
    end

    typedef struct packed {
        lcdcd_phase_e phase;
        logic [7:0] dout;
        logic doe;
        logic [7:0] rbuf;
        logic [7:0] shift;
        logic [2:0] bitcnt;
        logic scl_prev;
        logic disp_on;
        logic all_on;
        logic reverse;
        logic seg_normal;
        logic bias_high;
        logic com_reverse;
        logic power_save;
        logic rmw;
        logic init;
        logic [BW-1:0] busy_cnt;
        logic [LINE_W-1:0] start_line;
        logic [PAGE_W-1:0] page;
        logic [COL_W-1:0] col;
        logic [COL_W-1:0] col_saved;
        logic [NUM_PAGES-1:0][NUM_COLS-1:0][7:0] ram;
    } lcdcd_state_s;

    lcdcd_state_s s_ff;
    lcdcd_state_s nxt_s;

    lcdcd_pin_if #(.W(PIN_W)) pin_bus ();

    lcdcd_sync #(.W(PIN_W), .RESET_VAL(PIN_RST)) u_sync (
        .clk(CLK),
        .rst_n(RESETN),
        .ce(CE),
        .pins(pin_bus.syncer)
    );

    assign pin_bus.raw = {HARDWARE_RESET_N, IF_SERIAL, IF_6800, CS_N, COMMAND_DATA_SELECT,
                          RD_N_E, WR_N_RW, SCL, SDI, D_IN};

    logic hw_rst_n;
    logic serial;
    logic m6800;
    logic cs_n;
    logic cds;
    logic rde;
    logic wrrw;
    logic scl;
    logic sdi;
    logic [7:0] din;
    assign {hw_rst_n, serial, m6800, cs_n, cds, rde, wrrw, scl, sdi, din} = pin_bus.clean;

    logic p_wr_act;
    logic p_rd_act;
    logic [7:0] status;
    logic got;
    logic [7:0] val;
    logic is_data;
    logic rd_done;
    logic exec;
    logic [7:0] ram_word;

    // 6800 cycles are qualified by E high; 8080 by the low strobes
    assign p_wr_act = !serial && !cs_n && (m6800 ? (rde && !wrrw) : !wrrw); // R23
    assign p_rd_act = !serial && !cs_n && (m6800 ? (rde && wrrw) : !rde); // R23 R14

    always_comb begin
        status = 8'h00;
        status[STAT_BUSY_BIT] = s_ff.init; // R8
        status[STAT_ADC_BIT] = s_ff.seg_normal; // R9
        status[STAT_OFF_BIT] = !s_ff.disp_on; // R10
        status[STAT_RESET_BIT] = s_ff.init; // R11
    end

    assign ram_word = (s_ff.col < COL_W'(NUM_COLS)) ? s_ff.ram[s_ff.page][s_ff.col] : 8'h00;
    assign exec = got && hw_rst_n && !s_ff.init; // R8

    always_comb begin
        nxt_s = s_ff;
        got = 1'b0;
        val = 8'h00;
        is_data = 1'b0;
        rd_done = 1'b0;
        if (CE) begin
            nxt_s.scl_prev = scl;
            unique case (s_ff.phase)
                PH_IDLE: begin
                    if (p_wr_act) begin
                        nxt_s.phase = PH_WRITE;
                    end else if (p_rd_act) begin
                        nxt_s.phase = PH_READ;
                        nxt_s.doe = 1'b1;
                        nxt_s.dout = cds ? s_ff.rbuf : status; // R11
                    end
                end
                PH_WRITE: begin
                    if (!p_wr_act) begin
                        nxt_s.phase = PH_IDLE;
                        got = 1'b1;
                        val = din;
                        is_data = cds; // R23
                    end
                end
                PH_READ: begin
                    if (!p_rd_act) begin
                        nxt_s.phase = PH_IDLE;
                        nxt_s.doe = 1'b0;
                        rd_done = cds;
                    end
                end
                default: begin
                    nxt_s.phase = PH_IDLE;
                    nxt_s.doe = 1'b0;
                end
            endcase
            // Serial shifter is cleared by deselect and by the reset pin
            if (!serial || cs_n || !hw_rst_n) begin
                nxt_s.bitcnt = 3'h0;
                nxt_s.shift = 8'h00;
            end else if (scl && !s_ff.scl_prev && s_ff.phase == PH_IDLE) begin
                nxt_s.shift = {s_ff.shift[6:0], sdi}; // R24
                nxt_s.bitcnt = 3'(s_ff.bitcnt + 3'h1);
                if (s_ff.bitcnt == 3'h7) begin
                    got = 1'b1;
                    val = {s_ff.shift[6:0], sdi};
                    is_data = cds;
                end
            end
            // Read pipeline: the host sees the previous fetch, hence the dummy read
            if (rd_done) begin
                nxt_s.rbuf = ram_word; // R13
                if (!s_ff.rmw && s_ff.col < LAST_COL) begin
                    nxt_s.col = COL_W'(s_ff.col + 8'h01); // R7 R19 R26
                end
            end
            if (!hw_rst_n) begin
                nxt_s.disp_on = 1'b0;
                nxt_s.all_on = 1'b0;
                nxt_s.reverse = 1'b0;
                nxt_s.seg_normal = 1'b1;
                nxt_s.bias_high = 1'b0;
                nxt_s.power_save = 1'b0;
                nxt_s.com_reverse = 1'b0;
                nxt_s.rmw = 1'b0;
                nxt_s.start_line = RST_START_LINE;
                nxt_s.page = RST_PAGE;
                nxt_s.col = RST_COLUMN;
                nxt_s.init = 1'b1; // R11
                nxt_s.busy_cnt = BW'(RESET_BUSY_CYCLES);
            end else if (s_ff.init) begin // R8
                if (s_ff.busy_cnt == '0) begin
                    nxt_s.init = 1'b0;
                end else begin
                    nxt_s.busy_cnt = BW'(s_ff.busy_cnt - BW'(1));
                end
            end else if (got && is_data) begin
                if (s_ff.col < COL_W'(NUM_COLS)) begin
                    nxt_s.ram[s_ff.page][s_ff.col] =
                        (s_ff.page == IND_PAGE) ? {7'h00, val[0]} : val; // R5 R12
                end
                if (s_ff.col < LAST_COL) begin
                    nxt_s.col = COL_W'(s_ff.col + 8'h01); // R7 R12 R26
                end
            end else if (got) begin
                if (val == CMD_DISP_ON) begin
                    nxt_s.disp_on = 1'b1; // R1
                    nxt_s.power_save = 1'b0;
                end else if (val == CMD_DISP_OFF) begin
                    nxt_s.disp_on = 1'b0; // R1
                    if (s_ff.all_on) begin
                        nxt_s.power_save = 1'b1; // R2
                    end
                end else if (val[7:6] == GRP_START_LINE) begin
                    nxt_s.start_line = val[5:0]; // R3
                end else if (val[7:4] == GRP_PAGE && val[3:0] <= PAGE_MAX) begin
                    nxt_s.page = val[3:0]; // R4
                end else if (val[7:4] == GRP_COL_HIGH && val[3:0] <= COL_HIGH_MAX) begin
                    nxt_s.col = {val[3:0], s_ff.col[3:0]}; // R6
                end else if (val[7:4] == GRP_COL_LOW) begin
                    nxt_s.col = {s_ff.col[7:4], val[3:0]}; // R6
                end else if (val == CMD_ADC_NORMAL || val == CMD_ADC_REVERSE) begin
                    nxt_s.seg_normal = !val[0]; // R15
                end else if (val == CMD_POS_IMAGE || val == CMD_NEG_IMAGE) begin
                    nxt_s.reverse = val[0]; // R16
                end else if (val == CMD_ALL_OFF) begin
                    nxt_s.all_on = 1'b0; // R17
                    nxt_s.power_save = 1'b0;
                end else if (val == CMD_ALL_ON) begin
                    nxt_s.all_on = 1'b1; // R17
                    if (!s_ff.disp_on) begin
                        nxt_s.power_save = 1'b1;
                    end
                end else if (val == CMD_BIAS_LOW || val == CMD_BIAS_HIGH) begin
                    nxt_s.bias_high = val[0]; // R18
                end else if (val == CMD_RMW) begin
                    nxt_s.rmw = 1'b1; // R19
                    nxt_s.col_saved = s_ff.col;
                end else if (val == CMD_END) begin
                    if (s_ff.rmw) begin
                        nxt_s.col = s_ff.col_saved; // R20 R25
                    end
                    nxt_s.rmw = 1'b0; // R20
                end else if (val == CMD_SOFT_RESET) begin
                    nxt_s.start_line = RST_START_LINE; // R22
                    nxt_s.col = RST_COLUMN;
                    nxt_s.page = RST_PAGE;
                    nxt_s.com_reverse = 1'b0;
                    nxt_s.rmw = 1'b0;
                    nxt_s.init = 1'b1;
                    nxt_s.busy_cnt = BW'(RESET_BUSY_CYCLES);
                end else if (val[7:4] == GRP_COM_DIR) begin
                    nxt_s.com_reverse = val[3];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_ff <= '0;
            s_ff.phase <= PH_IDLE;
            s_ff.seg_normal <= 1'b1;
            s_ff.init <= 1'b1;
            s_ff.busy_cnt <= BW'(RESET_BUSY_CYCLES);
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign D_OUT = s_ff.dout;
    assign D_OE = s_ff.doe;
    assign DISPLAY_ON = s_ff.disp_on;
    assign ALL_POINTS_ON = s_ff.all_on;
    assign REVERSE_DISPLAY = s_ff.reverse;
    assign SEG_NORMAL = s_ff.seg_normal;
    assign BIAS_HIGH = s_ff.bias_high;
    assign COM_REVERSE = s_ff.com_reverse;
    assign POWER_SAVE = s_ff.power_save;
    assign RMW_ACTIVE = s_ff.rmw;
    assign BUSY = s_ff.init;
    assign START_LINE = s_ff.start_line;
    assign PAGE_ADDR = s_ff.page;
    assign COLUMN_ADDR = s_ff.col;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    logic cmd_take;
    logic data_take;
    assign cmd_take = exec && !is_data;
    assign data_take = exec && is_data;

    sequence rmw_enter_s;
        cmd_take && val == CMD_RMW;
    endsequence
    sequence rmw_end_s;
        cmd_take && val == CMD_END && s_ff.rmw;
    endsequence

    disp_onoff_a: assert property (cmd_take && (val == CMD_DISP_ON || val == CMD_DISP_OFF) // R1
        |=> s_ff.disp_on == $past(val[0])) else $error("display on/off not applied");
    psave_entry_a: assert property (cmd_take && val == CMD_DISP_OFF && s_ff.all_on // R2
        |=> s_ff.power_save && !s_ff.disp_on) else $error("power save not entered");
    start_line_a: assert property (cmd_take && val[7:6] == GRP_START_LINE // R3
        |=> s_ff.start_line == $past(val[5:0])) else $error("start line not loaded");
    page_range_a: assert property (s_ff.page <= PAGE_MAX) // R4
        else $error("page address above 8");
    ind_page_a: assert property (data_take && s_ff.page == IND_PAGE && s_ff.col < LAST_COL // R5
        |=> s_ff.ram[IND_PAGE][$past(s_ff.col)][7:1] == 7'h00) else $error("indicator bits kept");
    col_high_a: assert property (cmd_take && val[7:4] == GRP_COL_HIGH && val[3:0] <= COL_HIGH_MAX // R6
        |=> s_ff.col == {$past(val[3:0]), $past(s_ff.col[3:0])}) else $error("column high bad");
    col_step_a: assert property (data_take && s_ff.col < LAST_COL // R7 R12
        |=> s_ff.col == $past(s_ff.col) + 8'h01 && $stable(s_ff.page)) else $error("column step");
    col_stop_a: assert property (data_take && s_ff.col == LAST_COL // R26
        |=> s_ff.col == LAST_COL) else $error("column wrapped past last");
    busy_reject_a: assert property (got && s_ff.init && hw_rst_n // R8
        |=> $stable(s_ff.disp_on) && $stable(s_ff.page) && $stable(s_ff.col))
        else $error("command taken while busy");
    status_byte_a: assert property (CE && s_ff.phase == PH_IDLE && !p_wr_act && p_rd_act && !cds // R9 R10 R11
        |=> s_ff.doe && s_ff.dout == {$past(s_ff.init), $past(s_ff.seg_normal),
            !$past(s_ff.disp_on), $past(s_ff.init), 4'h0}) else $error("status byte wrong");
    serial_noread_a: assert property (serial && s_ff.phase == PH_IDLE |=> !s_ff.doe) // R14
        else $error("read driven in serial mode");
    adc_sel_a: assert property (cmd_take && (val == CMD_ADC_NORMAL || val == CMD_ADC_REVERSE) // R15
        |=> s_ff.seg_normal == !$past(val[0])) else $error("segment mapping not set");
    rmw_read_a: assert property (s_ff.rmw && rd_done && hw_rst_n // R19
        |=> $stable(s_ff.col)) else $error("column moved on read in RMW");
    rmw_enter_a: assert property (rmw_enter_s |=> s_ff.rmw && s_ff.col_saved == $past(s_ff.col)) // R19
        else $error("column not saved on RMW entry");
    rmw_end_a: assert property (rmw_end_s |=> s_ff.col == $past(s_ff.col_saved) && !s_ff.rmw) // R20
        else $error("end did not restore column");
    soft_reset_a: assert property (cmd_take && val == CMD_SOFT_RESET // R22
        |=> s_ff.start_line == RST_START_LINE && s_ff.col == RST_COLUMN
            && s_ff.page == RST_PAGE && !s_ff.rmw && s_ff.init) else $error("reset cmd incomplete");

endmodule : lcdcd_top

//--- common/lcdcd_pkg.sv
/*
 * Shared constants for the LCD command decoder: command codes and groups,
 * status bit positions, RAM geometry, reset values and the init busy time.
 * Assumes a 20 MHz system clock.
 */
package lcdcd_pkg;

    // Single-byte command codes
    localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
    localparam logic [7:0] CMD_DISP_ON = 8'hAF;
    localparam logic [7:0] CMD_ADC_NORMAL = 8'hA0;
    localparam logic [7:0] CMD_ADC_REVERSE = 8'hA1;
    localparam logic [7:0] CMD_BIAS_LOW = 8'hA2;
    localparam logic [7:0] CMD_BIAS_HIGH = 8'hA3;
    localparam logic [7:0] CMD_ALL_OFF = 8'hA4;
    localparam logic [7:0] CMD_ALL_ON = 8'hA5;
    localparam logic [7:0] CMD_POS_IMAGE = 8'hA6;
    localparam logic [7:0] CMD_NEG_IMAGE = 8'hA7;
    localparam logic [7:0] CMD_RMW = 8'hE0;
    localparam logic [7:0] CMD_END = 8'hEE;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hE2;

    // Command groups by upper bits
    localparam logic [1:0] GRP_START_LINE = 2'h1;
    localparam logic [3:0] GRP_COL_LOW = 4'h0;
    localparam logic [3:0] GRP_COL_HIGH = 4'h1;
    localparam logic [3:0] GRP_PAGE = 4'hB;
    localparam logic [3:0] GRP_COM_DIR = 4'hC;
    localparam logic [3:0] PAGE_MAX = 4'h8;
    localparam logic [3:0] COL_HIGH_MAX = 4'h8;

    // Status byte bit positions
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_ADC_BIT = 6;
    localparam int STAT_OFF_BIT = 5;
    localparam int STAT_RESET_BIT = 4;

    // Display RAM geometry
    localparam int NUM_COLS = 132;
    localparam int NUM_PAGES = 9;
    localparam logic [7:0] LAST_COL = 8'h83;
    localparam logic [3:0] IND_PAGE = 4'h8;
    localparam int COL_W = 8;
    localparam int PAGE_W = 4;
    localparam int LINE_W = 6;

    // Reset values
    localparam logic [5:0] RST_START_LINE = 6'h00;
    localparam logic [7:0] RST_COLUMN = 8'h00;
    localparam logic [3:0] RST_PAGE = 4'h0;

    // Initialisation busy time
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_BUSY_NS = 1000;
    localparam int RST_BUSY_CYC = (RST_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host bus cycle phase
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_WRITE = 3'b010,
        PH_READ = 3'b100
    } lcdcd_phase_e;

endpackage : lcdcd_pkg

//--- common/lcdcd_pin_if.sv
/*
 * Carrier between the pin synchroniser and the decoder: raw pin levels in,
 * filtered levels out. Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface lcdcd_pin_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport syncer (input raw, output clean);
    modport user (output raw, input clean);
endinterface : lcdcd_pin_if

//--- hdl/lcdcd_sync.sv
/*
 * Three-stage input synchroniser with agreement filter for a group of pins.
 * Assumes the pins are asynchronous to CLK; output updates per bit only
 * when the second and third stages agree.
 */
`timescale 1ns/1ps
module lcdcd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    lcdcd_pin_if.syncer pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } lcdcd_sync_s;

    lcdcd_sync_s s_ff;
    lcdcd_sync_s nxt_s;

    initial begin
        if (W < 1) $error("lcdcd_sync: W must be at least 1");
    end

    always_comb begin
        nxt_s = s_ff;
        if (ce) begin
            nxt_s.s1 = pins.raw;
            nxt_s.s2 = s_ff.s1;
            nxt_s.s3 = s_ff.s2;
            for (int i = 0; i < W; i++) begin
                if (s_ff.s2[i] == s_ff.s3[i]) begin
                    nxt_s.clean[i] = s_ff.s3[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign pins.clean = s_ff.clean;

endmodule : lcdcd_sync

//--- verification/lcdcd_host_model.sv
/* Host processor model: 8080 or 6800 bus cycles and 4-wire serial bytes.
   Assumes CLK is the device clock; pins change at its falling edge. */
`timescale 1ns/1ps
module lcdcd_host_model (
    input wire logic CLK,
    input wire logic [7:0] D_OUT,
    input wire logic D_OE,
    output logic IF_6800,
    output logic CS_N,
    output logic COMMAND_DATA_SELECT,
    output logic RD_N_E,
    output logic WR_N_RW,
    output logic SCL,
    output logic SDI,
    output logic [7:0] D_IN
);
    initial begin
        CS_N = 1'b1;
        COMMAND_DATA_SELECT = 1'b0;
        RD_N_E = 1'b1;
        WR_N_RW = 1'b1;
        SCL = 1'b0;
        SDI = 1'b0;
        D_IN = 8'h00;
        IF_6800 = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge CLK);
    endtask : gap
    // Mode change also moves the read strobe to its idle level for that bus style
    task automatic sel6800(input logic m);
        gap(1);
        IF_6800 = m;
        RD_N_E = !m;
        gap(8);
    endtask : sel6800
    // Released bus shows the inverse of the last byte, not a held value
    task automatic wr(input logic cds, input logic [7:0] d);
        gap(1);
        CS_N = 1'b0;
        COMMAND_DATA_SELECT = cds;
        D_IN = d;
        WR_N_RW = 1'b0;
        if (IF_6800) RD_N_E = 1'b1;
        gap(6);
        if (IF_6800) begin
            RD_N_E = 1'b0;
        end else begin
            WR_N_RW = 1'b1;
        end
        gap(6);
        CS_N = 1'b1;
        D_IN = ~d;
        WR_N_RW = 1'b1;
    endtask : wr
    task automatic rd(input logic cds, output logic [7:0] d, output logic ok);
        int n;
        gap(1);
        CS_N = 1'b0;
        COMMAND_DATA_SELECT = cds;
        RD_N_E = IF_6800;
        n = 0;
        while (D_OE !== 1'b1 && n < 20) begin
            gap(1);
            n++;
        end
        ok = (D_OE === 1'b1);
        gap(1);
        d = D_OUT;
        RD_N_E = !IF_6800;
        gap(8);
        CS_N = 1'b1;
    endtask : rd
    task automatic ser(input logic cds, input logic [7:0] d);
        gap(1);
        CS_N = 1'b0;
        COMMAND_DATA_SELECT = cds;
        for (int i = 7; i >= 0; i--) begin
            SDI = d[i];
            gap(6);
            SCL = 1'b1;
            gap(6);
            SCL = 1'b0;
        end
        SDI = ~d[0];
        gap(6);
        CS_N = 1'b1;
    endtask : ser
endmodule : lcdcd_host_model

//--- verification/lcdcd_top_bench.sv
/* Self-checking bench for the command decoder, driven through the host model.
   Assumes a 20 MHz clock and a reset busy time of 40 cycles, twice the default. */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module lcdcd_top_bench;
    import lcdcd_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hw_n = 1'b0;
    logic if_serial = 1'b0;
    logic if_6800, cs_n, cds, rd_n, wr_n, scl, sdi, d_oe, busy;
    logic display_on, all_on, rev, seg_n, bias_h, com_r, psave, rmw;
    logic [7:0] d_in, d_out, col;
    logic [5:0] start_line;
    logic [3:0] page;
    logic [7:0] obs;
    int fails = 0;
    int samples_checked = 0;
    assign obs = {display_on, all_on, rev, seg_n, bias_h, com_r, psave, rmw};
    always #25 clk = ~clk;
    lcdcd_host_model host_u (.CLK(clk), .D_OUT(d_out), .D_OE(d_oe), .CS_N(cs_n),
        .COMMAND_DATA_SELECT(cds), .RD_N_E(rd_n), .WR_N_RW(wr_n), .SCL(scl), .SDI(sdi),
        .D_IN(d_in), .IF_6800(if_6800));
    lcdcd_top #(.RESET_BUSY_CYCLES(40)) dut_u (.CLK(clk), .RESETN(resetn), .CE(1'b1),
        .HARDWARE_RESET_N(hw_n), .IF_SERIAL(if_serial), .IF_6800(if_6800), .CS_N(cs_n),
        .COMMAND_DATA_SELECT(cds), .RD_N_E(rd_n), .WR_N_RW(wr_n), .SCL(scl), .SDI(sdi),
        .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .DISPLAY_ON(display_on),
        .ALL_POINTS_ON(all_on), .REVERSE_DISPLAY(rev), .SEG_NORMAL(seg_n),
        .BIAS_HIGH(bias_h), .COM_REVERSE(com_r), .POWER_SAVE(psave), .RMW_ACTIVE(rmw),
        .BUSY(busy), .START_LINE(start_line), .PAGE_ADDR(page), .COLUMN_ADDR(col));
    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmd(input logic [7:0] c);
        host_u.wr(1'b0, c);
    endtask : cmd
    task automatic cmd_obs(input logic [7:0] c, input logic [7:0] e);
        cmd(c);
        `CHK(obs, e)
    endtask : cmd_obs
    task automatic colset(input logic [7:0] c);
        cmd({4'h1, c[7:4]});
        cmd({4'h0, c[3:0]});
    endtask : colset
    task automatic rdc(input logic s, input logic [7:0] e);
        logic [7:0] v;
        logic ok;
        host_u.rd(s, v, ok);
        if (ok !== 1'b1) begin
            fails++;
            report_and_stop();
        end
        `CHK(v, e)
    endtask : rdc
    task automatic dummy();
        logic [7:0] v;
        logic ok;
        host_u.rd(1'b1, v, ok);
    endtask : dummy
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            fails++;
            report_and_stop();
        end
    endtask : wait_idle
    initial begin
        logic [7:0] v;
        logic ok;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        cmd(CMD_DISP_ON);
        `CHK(display_on, 1'b0)
        rdc(1'b0, 8'hF0);
        hw_n = 1'b1;
        cmd(CMD_DISP_ON);
        `CHK(display_on, 1'b0)
        wait_idle();
        rdc(1'b0, 8'h60);
        cmd_obs(CMD_DISP_ON, 8'h90);
        rdc(1'b0, 8'h40);
        cmd_obs(CMD_DISP_OFF, 8'h10);
        cmd_obs(CMD_ADC_REVERSE, 8'h00);
        rdc(1'b0, 8'h20);
        cmd_obs(CMD_ADC_NORMAL, 8'h10);
        cmd_obs(CMD_NEG_IMAGE, 8'h30);
        cmd_obs(CMD_POS_IMAGE, 8'h10);
        cmd_obs(CMD_DISP_ON, 8'h90);
        cmd_obs(CMD_ALL_ON, 8'hD0);
        cmd_obs(CMD_DISP_OFF, 8'h52);
        cmd_obs(CMD_ALL_OFF, 8'h10);
        cmd_obs(CMD_BIAS_HIGH, 8'h18);
        cmd_obs(CMD_BIAS_LOW, 8'h10);
        cmd(8'h7F);
        `CHK(start_line, 6'h3F)
        cmd(8'hB8);
        `CHK(page, 4'h8)
        cmd(8'hB3);
        `CHK(page, 4'h3)
        colset(LAST_COL);
        host_u.wr(1'b1, 8'h5A);
        `CHK(col, LAST_COL)
        colset(8'h05);
        `CHK(col, 8'h05)
        host_u.wr(1'b1, 8'hAA);
        `CHK(col, 8'h06)
        host_u.wr(1'b1, 8'h3C);
        `CHK(col, 8'h07)
        `CHK(page, 4'h3)
        colset(8'h05);
        dummy();
        rdc(1'b1, 8'hAA);
        `CHK(col, 8'h07)
        colset(8'h05);
        cmd_obs(CMD_RMW, 8'h11);
        dummy();
        `CHK(col, 8'h05)
        host_u.wr(1'b1, 8'h55);
        `CHK(col, 8'h06)
        cmd_obs(CMD_END, 8'h10);
        `CHK(col, 8'h05)
        dummy();
        rdc(1'b1, 8'h55);
        cmd(8'hB8);
        colset(8'h00);
        host_u.wr(1'b1, 8'hFF);
        colset(8'h00);
        dummy();
        rdc(1'b1, 8'h01);
        cmd_obs(8'hC8, 8'h14);
        cmd(CMD_SOFT_RESET);
        wait_idle();
        `CHK({start_line, page, col, com_r}, 19'h0_0000)
        cmd(8'hB3);
        colset(8'h05);
        dummy();
        rdc(1'b1, 8'h55);
        host_u.sel6800(1'b1);
        cmd_obs(CMD_NEG_IMAGE, 8'h30);
        rdc(1'b0, 8'h60);
        rdc(1'b1, 8'h3C);
        if_serial = 1'b1;
        repeat (10) @(negedge clk);
        host_u.ser(1'b0, CMD_DISP_ON);
        `CHK(display_on, 1'b1)
        host_u.rd(1'b1, v, ok);
        `CHK(ok, 1'b0)
        report_and_stop();
    end
endmodule : lcdcd_top_bench
